// ==== rtl/cal_seq_map.vh ====
`ifndef CAL_SEQ_MAP_VH
`define CAL_SEQ_MAP_VH
// data word forced while the cores are off-line (two's complement mid-code)
`define MID_CODE 12'h000
// foreground procedure step lengths in core clocks
`define FG_CORE_CYCLES 16'h0400
`define FG_OFFSET_CYCLES 16'h0200
// background per-core calibration length in core clocks
`define BG_CORE_CYCLES 16'h0400
// delay settings are in units of 2 to this power (16) core clocks
`define DLY_UNIT_SHIFT 4
// core roles: active cores rotate through A, B, C
`define CORE_A 2'h0
`define CORE_B 2'h1
`define CORE_C 2'h2
// trim widths and reset values
`define OFS_TRIM_W 12
`define TIME_TRIM_W 8
`define OFS_TRIM_RST 12'h800
`define TIME_TRIM_RST 8'h80
`endif

// ==== rtl/cal_delay_timer.v ====
`timescale 1ns/10ps
// loadable down counter, done pulses one cycle when it reaches zero
module cal_delay_timer (
  input wire core_clk,
  input wire rst,
  input wire ce,
  input wire load,
  input wire [15:0] load_value,
  output reg busy,
  output reg done
);
  reg [15:0] count;

  // count down while busy
  always @(posedge core_clk) begin
    if (rst) begin
      count <= 16'h0000;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (load) begin
        count <= (load_value == 16'h0000) ? 16'h0001 : load_value;
        busy <= 1'b1;
      end else if (busy) begin
        if (count == 16'h0001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count <= count - 16'h0001;
      end
    end
  end
endmodule

// ==== rtl/adc_calibration_sequencer.v ====
`timescale 1ns/10ps
`include "cal_seq_map.vh"
module adc_calibration_sequencer (
  input wire core_clk,
  input wire rst,
  input wire ce,
  input wire calibration_enable,
  input wire hardware_calibration_trigger_pin,
  input wire software_calibration_trigger,
  input wire trigger_source_select,
  input wire background_calibration_enable,
  input wire low_power_enable,
  input wire low_power_swap_trigger_select,
  input wire [7:0] spare_core_sleep_delay,
  input wire [7:0] spare_core_settle_delay,
  input wire foreground_offset_calibration_enable,
  input wire background_offset_calibration_enable,
  input wire single_channel_mode,
  input wire [11:0] sample_in_a,
  input wire [11:0] sample_in_b,
  input wire trim_write,
  input wire [1:0] trim_write_sel,
  input wire [`OFS_TRIM_W-1:0] trim_write_data,
  input wire [2:0] bank_sel,
  input wire [`TIME_TRIM_W-1:0] bank_trim_write_data,
  input wire bank_trim_write,
  input wire bank_trim_phase,
  input wire [`OFS_TRIM_W-1:0] offset_result,
  output reg [11:0] sample_out_a,
  output reg [11:0] sample_out_b,
  output reg conversion_active,
  output reg foreground_calibration_complete,
  output reg background_active,
  output reg core_swap,
  output reg [1:0] spare_core,
  output reg spare_core_powered,
  output reg calibrating_core_valid,
  output reg offset_calibration_busy,
  output reg [`OFS_TRIM_W-1:0] offset_trim_zero_phase_a,
  output reg [`OFS_TRIM_W-1:0] offset_trim_zero_phase_b,
  output reg [`OFS_TRIM_W-1:0] offset_trim_minus90_phase,
  output reg [`TIME_TRIM_W-1:0] applied_bank_trim,
  output reg core_a_uses_minus90_clock
);
  localparam S_FG_CORE = 8'h01;
  localparam S_FG_OFS = 8'h02;
  localparam S_IDLE = 8'h04;
  localparam S_BG_SLEEP = 8'h08;
  localparam S_BG_WAKE = 8'h10;
  localparam S_BG_CAL = 8'h20;
  localparam S_BG_SWAP = 8'h40;
  localparam S_BG_WAIT = 8'h80;

  reg [7:0] state;
  reg [7:0] next_state;
  reg trig_prev;
  reg pin_prev;
  reg tmr_load;
  reg [15:0] tmr_value;
  reg [`TIME_TRIM_W-1:0] bank_trim [0:11];
  wire tmr_busy;
  wire tmr_done;
  wire trig_level;
  wire trig_rise;
  wire swap_rise;
  wire bg_ok;
  integer i;

  // trigger source mux and edge detect
  assign trig_level = trigger_source_select ? hardware_calibration_trigger_pin
    : software_calibration_trigger;
  assign trig_rise = trig_level & ~trig_prev;
  assign bg_ok = background_calibration_enable & calibration_enable
    & ~trigger_source_select & software_calibration_trigger;
  // background holds the soft bit high, so the pin edge must also be able to start a swap
  assign swap_rise = trig_rise | (hardware_calibration_trigger_pin & ~pin_prev);

  cal_delay_timer u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .load(tmr_load),
    .load_value(tmr_value),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // next state and timer loads
  always @* begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_value = `FG_CORE_CYCLES;
    case (state)
      S_FG_CORE: begin
        if (tmr_done) begin
          if (foreground_offset_calibration_enable) begin
            next_state = S_FG_OFS;
            tmr_load = 1'b1;
            tmr_value = `FG_OFFSET_CYCLES;
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      S_FG_OFS: begin
        if (tmr_done) next_state = S_IDLE;
      end
      S_IDLE: begin
        if (bg_ok) begin
          if (low_power_enable) begin
            next_state = S_BG_SLEEP;
            tmr_load = 1'b1;
            tmr_value = {spare_core_sleep_delay, 8'h00} >> (8 - `DLY_UNIT_SHIFT);
          end else begin
            next_state = S_BG_CAL;
            tmr_load = 1'b1;
            tmr_value = `BG_CORE_CYCLES;
          end
        end else if (trig_rise) begin
          next_state = S_FG_CORE;
          tmr_load = 1'b1;
          tmr_value = `FG_CORE_CYCLES;
        end
      end
      S_BG_SLEEP: begin
        // auto mode waits the sleep delay, trigger mode waits for an edge
        if (!bg_ok) begin
          next_state = S_IDLE;
        end else if (low_power_swap_trigger_select ? swap_rise : tmr_done) begin
          next_state = S_BG_WAKE;
          tmr_load = 1'b1;
          tmr_value = {spare_core_settle_delay, 8'h00} >> (8 - `DLY_UNIT_SHIFT);
        end
      end
      S_BG_WAKE: begin
        if (tmr_done) begin
          next_state = S_BG_CAL;
          tmr_load = 1'b1;
          tmr_value = `BG_CORE_CYCLES;
        end
      end
      S_BG_CAL: begin
        if (tmr_done) next_state = S_BG_SWAP;
      end
      S_BG_SWAP: begin
        next_state = S_BG_WAIT;
      end
      S_BG_WAIT: begin
        // rotate again; low-power sends the released core back to sleep
        if (!bg_ok) begin
          next_state = S_IDLE;
        end else if (low_power_enable) begin
          next_state = S_BG_SLEEP;
          tmr_load = 1'b1;
          tmr_value = {spare_core_sleep_delay, 8'h00} >> (8 - `DLY_UNIT_SHIFT);
        end else begin
          next_state = S_BG_CAL;
          tmr_load = 1'b1;
          tmr_value = `BG_CORE_CYCLES;
        end
      end
      default: begin
        next_state = S_FG_CORE;
        tmr_load = 1'b1;
      end
    endcase
  end

  // sequencer state, status and spare rotation
  always @(posedge core_clk) begin
    if (rst) begin
      state <= 8'h00; // default branch starts power-up calibration
      trig_prev <= 1'b0;
      pin_prev <= 1'b0;
      foreground_calibration_complete <= 1'b0;
      conversion_active <= 1'b0;
      background_active <= 1'b0;
      core_swap <= 1'b0;
      spare_core <= `CORE_C;
      spare_core_powered <= 1'b1;
      calibrating_core_valid <= 1'b0;
      offset_calibration_busy <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      trig_prev <= trig_level;
      pin_prev <= hardware_calibration_trigger_pin;
      if (next_state == S_FG_CORE)
        foreground_calibration_complete <= 1'b0;
      else if ((state == S_FG_CORE || state == S_FG_OFS) && next_state == S_IDLE)
        foreground_calibration_complete <= 1'b1;
      conversion_active <= ~(next_state == S_FG_CORE || next_state == S_FG_OFS);
      background_active <= next_state[3] | next_state[4] | next_state[5]
        | next_state[6] | next_state[7];
      core_swap <= (next_state == S_BG_SWAP); // glitches may follow
      if (next_state == S_BG_SWAP)
        spare_core <= (spare_core == `CORE_C) ? `CORE_A : spare_core + 2'h1;
      spare_core_powered <= ~(next_state == S_BG_SLEEP);
      calibrating_core_valid <= (next_state == S_BG_CAL);
      offset_calibration_busy <= (next_state == S_FG_OFS)
        | ((next_state == S_BG_CAL) & background_offset_calibration_enable);
    end
  end

  // sample path: mid-code while off-line
  always @(posedge core_clk) begin
    if (rst) begin
      sample_out_a <= `MID_CODE;
      sample_out_b <= `MID_CODE;
    end else if (ce) begin
      sample_out_a <= (next_state == S_FG_CORE || next_state == S_FG_OFS)
        ? `MID_CODE : sample_in_a;
      sample_out_b <= (next_state == S_FG_CORE || next_state == S_FG_OFS)
        ? `MID_CODE : sample_in_b;
    end
  end

  // offset trims: calibration results win, manual writes only in foreground idle
  always @(posedge core_clk) begin
    if (rst) begin
      offset_trim_zero_phase_a <= `OFS_TRIM_RST;
      offset_trim_zero_phase_b <= `OFS_TRIM_RST;
      offset_trim_minus90_phase <= `OFS_TRIM_RST;
    end else if (ce) begin
      if (state == S_FG_OFS && tmr_done) begin
        offset_trim_zero_phase_a <= offset_result;
        offset_trim_zero_phase_b <= offset_result;
        offset_trim_minus90_phase <= offset_result;
      end else if (state == S_BG_CAL && tmr_done && background_offset_calibration_enable) begin
        if (spare_core == `CORE_A) offset_trim_zero_phase_a <= offset_result;
        else if (spare_core == `CORE_B) offset_trim_zero_phase_b <= offset_result;
      end else if (trim_write && state == S_IDLE
          && !foreground_offset_calibration_enable
          && !background_offset_calibration_enable) begin
        case (trim_write_sel)
          2'h0: offset_trim_zero_phase_a <= trim_write_data;
          2'h1: offset_trim_zero_phase_b <= trim_write_data;
          2'h2: offset_trim_minus90_phase <= trim_write_data;
          default: offset_trim_zero_phase_a <= offset_trim_zero_phase_a;
        endcase
      end
    end
  end

  // bank timing trims, index = bank*2 + phase (phase 1 is minus-90)
  always @(posedge core_clk) begin
    if (rst) begin
      for (i = 0; i < 12; i = i + 1)
        bank_trim[i] <= `TIME_TRIM_RST;
    end else if (ce && bank_trim_write && state == S_IDLE && bank_sel < 3'h6) begin
      bank_trim[{bank_sel, bank_trim_phase}] <= bank_trim_write_data;
    end
  end

  // applied trim: minus-90 phase only for core A banks in single-channel mode
  always @(posedge core_clk) begin
    if (rst) begin
      applied_bank_trim <= `TIME_TRIM_RST;
      core_a_uses_minus90_clock <= 1'b0;
    end else if (ce) begin
      core_a_uses_minus90_clock <= single_channel_mode;
      if (bank_sel < 3'h2 && single_channel_mode)
        applied_bank_trim <= bank_trim[{bank_sel, 1'b1}];
      else if (bank_sel < 3'h6)
        applied_bank_trim <= bank_trim[{bank_sel, 1'b0}];
      else
        applied_bank_trim <= `TIME_TRIM_RST;
    end
  end
endmodule

// ==== dv/adc_calibration_sequencer_asserts.sv ====
`timescale 1ns/10ps
// watches start-up, triggers, output forcing, swaps and trim locking
module cal_seq_checker (
  input wire core_clk,
  input wire rst,
  input wire ce,
  input wire hardware_calibration_trigger_pin,
  input wire software_calibration_trigger,
  input wire trigger_source_select,
  input wire background_calibration_enable,
  input wire foreground_offset_calibration_enable,
  input wire background_offset_calibration_enable,
  input wire single_channel_mode,
  input wire trim_write,
  input wire [11:0] sample_out_a,
  input wire conversion_active,
  input wire foreground_calibration_complete,
  input wire background_active,
  input wire core_swap,
  input wire spare_core_powered,
  input wire calibrating_core_valid,
  input wire [11:0] offset_trim_zero_phase_a,
  input wire core_a_uses_minus90_clock
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire done = foreground_calibration_complete;
  wire idle = ce && done && !background_active && !background_calibration_enable;
  reg [11:0] fg_cnt;
  // counts clocks spent with the complete flag low
  always @(posedge core_clk) begin
    if (rst || done) fg_cnt <= 12'h000;
    else if (ce && fg_cnt != 12'hFFF) fg_cnt <= fg_cnt + 12'h001;
  end
  sequence fg_entered;
    !done && !conversion_active;
  endsequence
  chk_mid_code: assert property (!conversion_active |-> sample_out_a == 12'h000)
    else $error("samples not mid code");
  chk_no_conversion: assert property (!done && !background_active |-> !conversion_active)
    else $error("converting during calibration");
  chk_fg_length: assert property (
    $rose(done) |-> fg_cnt >= 12'h400 && fg_cnt <= 12'h609 && conversion_active
  ) else $error("foreground length wrong");
  chk_soft_start: assert property (
    idle && !trigger_source_select && $rose(software_calibration_trigger) |=> fg_entered
  ) else $error("soft trigger not taken");
  chk_pin_start: assert property (
    idle && trigger_source_select && $rose(hardware_calibration_trigger_pin) |=> fg_entered
  ) else $error("pin trigger not taken");
  chk_swap_pulse: assert property (
    core_swap |-> background_active && conversion_active ##1 !core_swap
  ) else $error("bad swap pulse");
  chk_cal_powered: assert property (calibrating_core_valid |-> spare_core_powered)
    else $error("calibrating unpowered core");
  chk_minus90_clock: assert property (
    ce |=> core_a_uses_minus90_clock == $past(single_channel_mode)
  ) else $error("core a clock phase wrong");
  chk_trim_locked: assert property (
    trim_write && (idle && (foreground_offset_calibration_enable ||
    background_offset_calibration_enable) || background_active &&
    !background_offset_calibration_enable) |=> $stable(offset_trim_zero_phase_a)
  ) else $error("locked trim written");
endmodule
bind adc_calibration_sequencer cal_seq_checker i_chk (.*);

// ==== dv/cal_controller_model.sv ====
`timescale 1ns/10ps
// system controller: makes trigger edges on request, holds soft trigger for background
module cal_controller_model (
  input wire core_clk,
  input wire rst,
  input wire foreground_calibration_complete,
  input wire fire_hw,
  input wire fire_sw,
  input wire hold_sw,
  output reg hardware_calibration_trigger_pin,
  output reg software_calibration_trigger,
  output reg ready
);
  // ready latches once power-up calibration ends; the test checks it after waiting for the complete flag
  always @(posedge core_clk) begin
    if (rst) begin
      hardware_calibration_trigger_pin <= 1'b0;
      software_calibration_trigger <= 1'b0;
      ready <= 1'b0;
    end else begin
      ready <= ready | foreground_calibration_complete;
      hardware_calibration_trigger_pin <= fire_hw;
      software_calibration_trigger <= fire_sw | hold_sw;
    end
  end
endmodule

// ==== dv/test_adc_calibration_sequencer.sv ====
`timescale 1ns/10ps
module test_adc_calibration_sequencer;
  reg core_clk = 1'b0, rst = 1'b1, ce = 1'b1, calibration_enable = 1'b0, hold_sw = 1'b0;
  reg trigger_source_select = 1'b0, background_calibration_enable = 1'b0, fire_hw = 1'b0;
  reg low_power_enable = 1'b0, low_power_swap_trigger_select = 1'b0, fire_sw = 1'b0;
  reg foreground_offset_calibration_enable = 1'b0, background_offset_calibration_enable = 1'b0;
  reg trim_write = 1'b0, bank_trim_write = 1'b0, bank_trim_phase = 1'b0, single_channel_mode = 1'b0;
  reg [7:0] spare_core_sleep_delay = 8'h01, spare_core_settle_delay = 8'h01;
  reg [7:0] bank_trim_write_data = 8'h00;
  reg [11:0] sample_in_a = 12'h000, sample_in_b = 12'hFFF, trim_write_data = 12'h000;
  reg [11:0] offset_result = 12'h5A5;
  reg [1:0] trim_write_sel = 2'h0;
  reg [2:0] bank_sel = 3'h0;
  wire [11:0] sample_out_a, sample_out_b, offset_trim_zero_phase_a, offset_trim_zero_phase_b;
  wire [11:0] offset_trim_minus90_phase;
  wire [7:0] applied_bank_trim;
  wire [1:0] spare_core;
  wire conversion_active, foreground_calibration_complete, background_active, core_swap;
  wire spare_core_powered, calibrating_core_valid, offset_calibration_busy;
  wire core_a_uses_minus90_clock, hardware_calibration_trigger_pin, software_calibration_trigger;
  wire ready;
  int miscompares = 0, checks = 0, i;
  adc_calibration_sequencer i_dut (.*);
  cal_controller_model i_ctl (.*);
  always #4 core_clk = ~core_clk;
  // moving input data
  always @(posedge core_clk) sample_in_a <= sample_in_a + 12'h001;
  task tally_and_finish;
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task chk(input string what, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // bounded wait for a swap pulse or for the complete flag
  task wait_for(input bit swap);
    int k;
    k = 0;
    while ((swap ? core_swap : foreground_calibration_complete) !== 1'b1 && k < 4000) begin
      tick(1);
      k++;
    end
    if (k == 4000) begin
      miscompares++;
      $display("[ERR] wait_for expected 1 seen 0");
    end
  endtask
  // one trim write: bank timing trim or offset trim
  task wr(input bit bank, input logic [2:0] sel, input logic [11:0] d);
    if (bank) bank_trim_write <= 1'b1;
    else trim_write <= 1'b1;
    bank_sel <= sel;
    trim_write_sel <= sel[1:0];
    bank_trim_write_data <= d[7:0];
    trim_write_data <= d;
    tick(1);
    bank_trim_write <= 1'b0;
    trim_write <= 1'b0;
    tick(1);
  endtask
  task fire(input bit hw);
    if (hw) fire_hw <= 1'b1;
    else fire_sw <= 1'b1;
    tick(1);
    fire_hw <= 1'b0;
    fire_sw <= 1'b0;
    tick(5);
  endtask
  initial begin
    tick(20);
    rst <= 1'b0;
    tick(10);
    chk("conversion", 12'h000, conversion_active);
    chk("sample_a", 12'h000, sample_out_a);
    wait_for(1'b0);
    tick(1);
    chk("ready", 12'h001, ready);
    chk("ofs_a_rst", 12'h800, offset_trim_zero_phase_a);
    chk("bank_rst", 12'h080, applied_bank_trim);
    for (i = 0; i < 3; i++) wr(1'b0, i[2:0], 12'h100 + i);
    chk("ofs_a", 12'h100, offset_trim_zero_phase_a);
    chk("ofs_b", 12'h101, offset_trim_zero_phase_b);
    chk("ofs_m90", 12'h102, offset_trim_minus90_phase);
    for (i = 0; i < 6; i++) wr(1'b1, i[2:0], 12'h020 + i);
    for (i = 0; i < 6; i++) begin
      bank_sel <= i[2:0];
      tick(2);
      chk("bank", 12'h020 + i, applied_bank_trim);
    end
    // single-channel picks the minus-90 phase trim of bank 0
    single_channel_mode <= 1'b1;
    bank_trim_phase <= 1'b1;
    wr(1'b1, 3'h0, 12'h055);
    tick(2);
    chk("bank_m90", 12'h055, applied_bank_trim);
    chk("m90_clock", 12'h001, core_a_uses_minus90_clock);
    single_channel_mode <= 1'b0;
    // each source starts calibration only when selected
    for (i = 0; i < 2; i++) begin
      trigger_source_select <= i[0];
      fire(!i[0]);
      chk("ignored", 12'h001, foreground_calibration_complete);
      fire(i[0]);
      chk("started", 12'h000, foreground_calibration_complete);
      chk("sample_b", 12'h000, sample_out_b);
      wait_for(1'b0);
      chk("finished", 12'h001, conversion_active);
    end
    foreground_offset_calibration_enable <= 1'b1;
    trigger_source_select <= 1'b0;
    fire(1'b0);
    tick(1100);
    chk("ofs_busy", 12'h001, offset_calibration_busy);
    wait_for(1'b0);
    chk("ofs_cal", 12'h5A5, offset_trim_zero_phase_a);
    wr(1'b0, 3'h0, 12'h3C3);
    chk("ofs_locked", 12'h5A5, offset_trim_zero_phase_a);
    foreground_offset_calibration_enable <= 1'b0;
    // background rotation: enables first, then soft trigger held high
    calibration_enable <= 1'b1;
    background_calibration_enable <= 1'b1;
    tick(2);
    hold_sw <= 1'b1;
    wait_for(1'b1);
    tick(3);
    chk("spare_1", 12'h000, spare_core);
    wr(1'b0, 3'h1, 12'h3C3);
    chk("bg_locked", 12'h5A5, offset_trim_zero_phase_b);
    wait_for(1'b1);
    tick(3);
    chk("spare_2", 12'h001, spare_core);
    chk("bg_live", 12'h001, conversion_active);
    chk("bg_active", 12'h001, background_active);
    low_power_enable <= 1'b1;
    wait_for(1'b1);
    tick(4);
    chk("sleeping", 12'h000, spare_core_powered);
    tick(24);
    chk("woken", 12'h001, spare_core_powered);
    chk("settling", 12'h000, calibrating_core_valid);
    wait_for(1'b1);
    chk("lp_swap", 12'h001, core_swap);
    chk("lp_spare", 12'h000, spare_core);
    // trigger-started swaps: the spare sleeps past its delay until the pin edge
    low_power_swap_trigger_select <= 1'b1;
    tick(40);
    chk("lp_held", 12'h000, spare_core_powered);
    fire(1'b1);
    chk("low_power_swap_trigger_select_wake", 12'h001, spare_core_powered);
    wait_for(1'b1);
    chk("trig_spare", 12'h001, spare_core);
    tally_and_finish;
  end
  // cut a hang short
  initial begin
    tick(40000);
    miscompares++;
    $display("[ERR] watchdog expected finish seen timeout");
    tally_and_finish;
  end
endmodule
